// ==== rtl/bcs_regs.vh ====
/*
 holds the constants of the block call sequencer: opcodes, field positions,
 reset values and control register offsets.
 assumes it is included by its bare name in every design file that needs it.
*/
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// instruction word layout: opcode in [15:8], operand in [7:0]
`define BCS_OP_MSB 15
`define BCS_OP_LSB 8
`define BCS_ARG_MSB 7
`define BCS_ARG_LSB 0

`define BCS_OP_CALL_U 8'h01
`define BCS_OP_CALL_C 8'h02
`define BCS_OP_SEL_DB 8'h03
`define BCS_OP_GEN_DB 8'h04
`define BCS_OP_RET 8'h05
`define BCS_OP_RET_U 8'h06
`define BCS_OP_RET_C 8'h07
`define BCS_OP_HALT 8'h08
`define BCS_OP_ADD 8'h09
`define BCS_OP_SUB 8'h0A
`define BCS_OP_DISP 8'h0B
`define BCS_NOP_ZEROS 16'h0000
`define BCS_NOP_ONES 16'hFFFF

// block type in operand of calls is taken from opcode-side field [1:0] of type reg
`define BCS_MIN_GEN_DB 8'h02

// register offsets of the control port
`define BCS_REG_CTRL 4'h0
`define BCS_REG_STATUS 4'h1
`define BCS_REG_ACC1 4'h2
`define BCS_REG_ACC2 4'h3
`define BCS_REG_PC 4'h4
`define BCS_REG_BLOCK 4'h5
`define BCS_REG_DB 4'h6
`define BCS_REG_FREE 4'h7
`define BCS_REG_START 4'h8

// control bits
`define BCS_CTRL_RUN 0
`define BCS_CTRL_ERR_OB 1
`define BCS_CTRL_COMPRESS 2

// status bits
`define BCS_ST_RUN 0
`define BCS_ST_TRANSFER_ERROR_INDICATION 1
`define BCS_ST_STS 2
`define BCS_ST_RLO 3
`define BCS_ST_CC0 4
`define BCS_ST_CC1 5
`define BCS_ST_HALT_PEND 6
`define BCS_ST_STK_ERR 7

`define BCS_RST_CTRL 16'h0000
`define BCS_RST_FREE 16'h1000
`define BCS_RST_START 16'h0000
`define BCS_ERR_OB 8'h1B

`endif

// ==== rtl/bcs_dir.v ====
/*
 block address list of data blocks: for each number a valid flag, a start
 address and a length, with a bump allocator that reclaims deleted space only on compression.
 assumes one clock and combinational lookups by the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"

module bcs_dir #(
  parameter AW = 16,
  parameter NBLK = 256
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [7:0] look_num_i,
  output wire look_valid_o,
  output wire [AW-1:0] look_base_o,
  input wire gen_i,
  input wire [7:0] gen_num_i,
  input wire [AW-1:0] gen_len_i,
  input wire del_i,
  input wire compress_i,
  input wire [AW-1:0] free_init_i,
  output wire [AW-1:0] free_o,
  output wire fits_o
);

  reg [NBLK-1:0] valid_r;
  reg [AW-1:0] base_r [0:NBLK-1];
  reg [AW-1:0] len_r [0:NBLK-1];
  reg [AW-1:0] top_r;
  reg [AW-1:0] dead_r;

  assign look_valid_o = valid_r[look_num_i];
  assign look_base_o = base_r[look_num_i];
  assign free_o = free_init_i - top_r;
  assign fits_o = (gen_len_i <= free_o);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_r <= {NBLK{1'b0}};
      top_r <= {AW{1'b0}};
      dead_r <= {AW{1'b0}};
    end else if (compress_i) begin
      // dead space only returns on compression
      top_r <= top_r - dead_r;
      dead_r <= {AW{1'b0}};
    end else if (gen_i) begin
      valid_r[gen_num_i] <= 1'b1;
      top_r <= top_r + gen_len_i;
    end else if (del_i) begin
      valid_r[gen_num_i] <= 1'b0;
      dead_r <= dead_r + len_r[gen_num_i];
    end
  end

  // storage of base and length has no reset: only read under valid
  always @(posedge mclk_i) begin
    if (gen_i && !compress_i) begin
      base_r[gen_num_i] <= top_r;
      len_r[gen_num_i] <= gen_len_i;
    end
  end

endmodule // bcs_dir
`default_nettype wire

// ==== rtl/bcs_seq.v ====
/*
 block call sequencer: fetches 16-bit program words, executes calls, block
 ends, data block select/generate/delete, add/subtract, halt and no-ops.
 assumes program memory answers a fetch one cycle later and the code block
 start table answers combinationally from outside through code_blk_o (address space outside).
*/
// Overview of operation
// RL1 - arithmetic ignores logic bit, result in accumulator one, accumulator two kept
// RL2 - arithmetic keeps logic bit, updates condition codes from result
// RL3 - unconditional call enters block 0 to 255, logic bit unchanged
// RL4 - conditional call enters only when logic bit 1, then bit forced 1
// RL5 - data block select unconditional, logic bit kept, later accesses use it
// RL6 - select never creates blocks; only existing blocks selectable
// RL7 - program loads word count in accumulator one first; numbers 2 to 255
// RL8 - generate allocates value plus one words and enters address list
// RL9 - length zero deletes block from list, then block is nonexistent
// RL10 - deleted storage stays dead until memory compression
// RL11 - generating an existing block has no effect
// RL12 - oversize block stops with transfer error or branches to error block
// RL13 - block end returns to caller, logic bit passed unchanged
// RL14 - program ends each code block with block end
// RL15 - logic chain does not continue into caller after return
// RL16 - unconditional block end returns regardless of logic bit
// RL17 - conditional end returns when bit 1, else forces 1 and continues
// RL18 - halt finishes scan to end, then stops with stop-statement indication
// RL19 - both no-op words all zeros or all ones, no action
// RL20 - program may use no-op words to reserve or overwrite places
// RL21 - program holds every called block before execution starts
// RL22 - return stack records caller and position, popped on every block end that returns
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"

module bcs_seq #(
  parameter AW = 16,
  parameter DEPTH = 16,
  parameter SPW = 4
) (
  input wire mclk_i,
  input wire rst_n_i,
  // control port
  input wire [3:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // program memory fetch
  output reg [AW-1:0] prog_addr_o,
  output wire prog_rd_o,
  input wire [15:0] prog_data_i,
  // code block start lookup, combinational
  output wire [9:0] code_blk_o,
  input wire [AW-1:0] code_base_i,
  input wire code_valid_i,
  // data access base for later data operations
  output reg [AW-1:0] db_base_o,
  output reg db_valid_o,
  output reg [7:0] db_num_o,
  output wire running_o
);

  localparam S_IDLE = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_EXEC = 3'd2;
  localparam S_STOP = 3'd3;

  reg [2:0] state_r;
  reg [15:0] ctrl_r;
  reg [AW-1:0] pc_r;
  reg [9:0] blk_r;
  reg rlo_r;
  reg first_r;
  reg [1:0] cc_r;
  reg [15:0] acc1_r;
  reg [15:0] acc2_r;
  reg halt_pend_r;
  reg transfer_error_indication_r;
  reg sts_r;
  reg stk_err_r;
  reg [15:0] free_r;
  reg [15:0] start_r;
  reg [AW-1:0] stk_pc_r [0:DEPTH-1];
  reg [9:0] stk_blk_r [0:DEPTH-1];
  reg [SPW-1:0] sp_r;

  wire [7:0] op = prog_data_i[`BCS_OP_MSB:`BCS_OP_LSB];
  wire [7:0] arg = prog_data_i[`BCS_ARG_MSB:`BCS_ARG_LSB];
  wire is_exec = (state_r == S_EXEC);
  wire [15:0] sum = acc2_r + acc1_r;
  wire [15:0] diff = acc2_r - acc1_r;
  wire [AW-1:0] pc_inc = pc_r + {{(AW-1){1'b0}}, 1'b1};
  wire [SPW-1:0] sp_inc = sp_r + {{(SPW-1){1'b0}}, 1'b1};
  wire [SPW-1:0] sp_dec = sp_r - {{(SPW-1){1'b0}}, 1'b1};
  // last slot stays spare so a full stack is seen before the pointer wraps
  wire stk_full = (sp_r == DEPTH - 1);

  // arithmetic result and codes, shared by add and subtract
  reg [15:0] alu_nxt;
  reg [1:0] cc_nxt;

  always @* begin
    alu_nxt = diff;
    if (op == `BCS_OP_ADD) begin
      alu_nxt = sum;
    end
    cc_nxt = {alu_nxt[15], (alu_nxt == 16'h0000)};
  end

  // directory of data blocks
  wire dir_valid;
  wire [AW-1:0] dir_base;
  wire [AW-1:0] dir_free;
  wire dir_fits;
  wire [AW-1:0] gen_len = acc1_r[AW-1:0] + {{(AW-1){1'b0}}, 1'b1};
  wire gen_op = is_exec && (op == `BCS_OP_GEN_DB) && (arg >= `BCS_MIN_GEN_DB);
  wire gen_zero = (acc1_r == 16'h0000);
  wire do_gen = gen_op && !gen_zero && !dir_valid && dir_fits;
  wire do_del = gen_op && gen_zero && dir_valid;
  wire gen_over = gen_op && !gen_zero && !dir_valid && !dir_fits;

  // a taken call and the error branch share one push path
  wire call_take = is_exec && code_valid_i &&
                   ((op == `BCS_OP_CALL_U) || ((op == `BCS_OP_CALL_C) && rlo_r));
  wire err_take = gen_over && ctrl_r[`BCS_CTRL_ERR_OB] && code_valid_i;
  wire push_en = (call_take || err_take) && !stk_full;

  bcs_dir #(
    .AW(AW),
    .NBLK(256)
  ) u_dir (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .look_num_i(arg),
    .look_valid_o(dir_valid),
    .look_base_o(dir_base),
    .gen_i(do_gen),
    .gen_num_i(arg),
    .gen_len_i(gen_len),
    .del_i(do_del),
    .compress_i(reg_wr_i && (reg_addr_i == `BCS_REG_CTRL) &&
                reg_wdata_i[`BCS_CTRL_COMPRESS]),
    .free_init_i(free_r[AW-1:0]),
    .free_o(dir_free),
    .fits_o(dir_fits)
  );

  // block type sits in opcode low bits of the call word's upper operand use
  assign code_blk_o = (is_exec && (op == `BCS_OP_CALL_U || op == `BCS_OP_CALL_C)) ?
                      {prog_data_i[`BCS_OP_LSB+1:`BCS_OP_LSB] ^ 2'b00, arg} :
                      (gen_over ? {2'b00, `BCS_ERR_OB} : 10'h000);
  assign prog_rd_o = (state_r == S_FETCH);
  assign running_o = (state_r == S_FETCH) || (state_r == S_EXEC);

  // stack storage has no reset: entries are only read below the pointer
  always @(posedge mclk_i) begin
    if (push_en) begin
      stk_pc_r[sp_r] <= pc_inc;
      stk_blk_r[sp_r] <= blk_r;
    end
  end

  function is_ret;
    input [15:0] w;
    begin
      is_ret = (w[15:8] == `BCS_OP_RET) || (w[15:8] == `BCS_OP_RET_U) ||
               (w[15:8] == `BCS_OP_RET_C);
    end
  endfunction

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      ctrl_r <= `BCS_RST_CTRL;
      pc_r <= {AW{1'b0}};
      blk_r <= 10'h000;
      rlo_r <= 1'b0;
      first_r <= 1'b1;
      cc_r <= 2'b00;
      acc1_r <= 16'h0000;
      acc2_r <= 16'h0000;
      halt_pend_r <= 1'b0;
      transfer_error_indication_r <= 1'b0;
      sts_r <= 1'b0;
      stk_err_r <= 1'b0;
      free_r <= `BCS_RST_FREE;
      start_r <= `BCS_RST_START;
      sp_r <= {SPW{1'b0}};
      prog_addr_o <= {AW{1'b0}};
      db_base_o <= {AW{1'b0}};
      db_valid_o <= 1'b0;
      db_num_o <= 8'h00;
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= 16'h0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `BCS_REG_CTRL: reg_rdata_o <= ctrl_r;
          `BCS_REG_STATUS: reg_rdata_o <= {8'h00, stk_err_r, halt_pend_r, cc_r,
                                            rlo_r, sts_r, transfer_error_indication_r, running_o};
          `BCS_REG_ACC1: reg_rdata_o <= acc1_r;
          `BCS_REG_ACC2: reg_rdata_o <= acc2_r;
          `BCS_REG_PC: reg_rdata_o <= pc_r[15:0];
          `BCS_REG_BLOCK: reg_rdata_o <= {6'h00, blk_r};
          `BCS_REG_DB: reg_rdata_o <= {7'h00, db_valid_o, db_num_o};
          `BCS_REG_FREE: reg_rdata_o <= dir_free[15:0];
          `BCS_REG_START: reg_rdata_o <= start_r;
          default: reg_rdata_o <= 16'h0000;
        endcase
      end
      if (reg_wr_i) begin
        case (reg_addr_i)
          `BCS_REG_CTRL: ctrl_r <= reg_wdata_i & 16'h0003;
          `BCS_REG_ACC1: acc1_r <= reg_wdata_i;
          `BCS_REG_ACC2: acc2_r <= reg_wdata_i;
          `BCS_REG_FREE: free_r <= reg_wdata_i;
          `BCS_REG_START: start_r <= reg_wdata_i;
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE: begin
          if (ctrl_r[`BCS_CTRL_RUN]) begin
            // restart clears stop indications; scan begins at main block
            transfer_error_indication_r <= 1'b0;
            sts_r <= 1'b0;
            halt_pend_r <= 1'b0;
            sp_r <= {SPW{1'b0}};
            pc_r <= start_r[AW-1:0];
            prog_addr_o <= start_r[AW-1:0];
            blk_r <= 10'h001;
            first_r <= 1'b1;
            state_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          state_r <= S_EXEC;
        end
        S_EXEC: begin
          state_r <= S_FETCH;
          pc_r <= pc_inc;
          prog_addr_o <= pc_inc;
          if (prog_data_i == `BCS_NOP_ZEROS || prog_data_i == `BCS_NOP_ONES) begin
            // RL19 no-op words
            state_r <= S_FETCH;
          end else begin
            case (op)
              `BCS_OP_ADD, `BCS_OP_SUB: begin
                // RL1 result to accumulator one
                acc1_r <= alu_nxt;
                // RL2 codes from result
                cc_r <= cc_nxt;
              end
              `BCS_OP_CALL_U, `BCS_OP_CALL_C: begin
                // RL3 unconditional entry
                // RL4 conditional entry, then forced one
                if (call_take) begin
                  // RL22 push caller
                  if (stk_full) begin
                    stk_err_r <= 1'b1;
                  end else begin
                    sp_r <= sp_inc;
                    blk_r <= code_blk_o;
                    pc_r <= code_base_i;
                    prog_addr_o <= code_base_i;
                  end
                end
                if (op == `BCS_OP_CALL_C)
                  rlo_r <= 1'b1;
                first_r <= 1'b1;
              end
              `BCS_OP_SEL_DB: begin
                // RL5 RL6 only existing blocks become current
                if (dir_valid) begin
                  db_base_o <= dir_base;
                  db_num_o <= arg;
                  db_valid_o <= 1'b1;
                end
              end
              `BCS_OP_GEN_DB: begin
                // RL8 RL9 RL10 RL11 list update in the directory
                if (do_del && db_num_o == arg)
                  db_valid_o <= 1'b0;
                // RL12 oversize block
                if (gen_over) begin
                  if (err_take && !stk_full) begin
                    sp_r <= sp_inc;
                    blk_r <= code_blk_o;
                    pc_r <= code_base_i;
                    prog_addr_o <= code_base_i;
                  end else begin
                    transfer_error_indication_r <= 1'b1;
                    ctrl_r[`BCS_CTRL_RUN] <= 1'b0;
                    state_r <= S_STOP;
                  end
                end
              end
              `BCS_OP_RET, `BCS_OP_RET_U, `BCS_OP_RET_C: begin
                // RL17 conditional end continues with bit forced one
                if (op == `BCS_OP_RET_C && !rlo_r) begin
                  rlo_r <= 1'b1;
                end else if (sp_r == {SPW{1'b0}}) begin
                  // RL18 end of scan: stop if halt pending, else rescan
                  if (halt_pend_r) begin
                    sts_r <= 1'b1;
                    ctrl_r[`BCS_CTRL_RUN] <= 1'b0;
                    state_r <= S_STOP;
                  end else begin
                    pc_r <= start_r[AW-1:0];
                    prog_addr_o <= start_r[AW-1:0];
                  end
                  first_r <= 1'b1;
                end else begin
                  // RL13 RL16 return, logic bit carried along
                  // RL22 pop caller
                  pc_r <= stk_pc_r[sp_dec];
                  prog_addr_o <= stk_pc_r[sp_dec];
                  blk_r <= stk_blk_r[sp_dec];
                  sp_r <= sp_dec;
                  // RL15 fresh logic chain in caller
                  first_r <= 1'b1;
                end
              end
              `BCS_OP_HALT: begin
                // RL18 finish scan first
                halt_pend_r <= 1'b1;
              end
              default: ;
            endcase
          end
        end
        S_STOP: begin
          // restart from the mode selector by writing the run bit again
          if (ctrl_r[`BCS_CTRL_RUN])
            state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // bcs_seq
`default_nettype wire

// ==== tb/bcs_seq_monitor.sv ====
/*
 port checker of the block call sequencer, bound to bcs_seq.
 assumes one clock, asynchronous active-low reset, fetch then execute cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"
module bcs_seq_monitor #(
  parameter int AW = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [AW-1:0] prog_addr_o,
  input wire logic prog_rd_o,
  input wire logic [15:0] prog_data_i,
  input wire logic [9:0] code_blk_o,
  input wire logic [AW-1:0] code_base_i,
  input wire logic [AW-1:0] db_base_o,
  input wire logic db_valid_o,
  input wire logic [7:0] db_num_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire [7:0] op = prog_data_i[15:8];
  wire nop = prog_data_i == `BCS_NOP_ZEROS || prog_data_i == `BCS_NOP_ONES || op == `BCS_OP_DISP;
  property p_arith_linear;
    prog_rd_o ##1 (op == `BCS_OP_ADD || op == `BCS_OP_SUB) |=>
      prog_rd_o && prog_addr_o == $past(prog_addr_o, 2) + 1'b1;
  endproperty
  a_arith_linear: assert property (p_arith_linear)
    else $error("arithmetic word broke the sequence");
  property p_halt_goes_on;
    prog_rd_o ##1 op == `BCS_OP_HALT |=> prog_rd_o && prog_addr_o == $past(prog_addr_o, 2) + 1'b1;
  endproperty
  a_halt_goes_on: assert property (p_halt_goes_on)
    else $error("halt stopped the scan at once");
  property p_select_linear;
    prog_rd_o ##1 op == `BCS_OP_SEL_DB |=> prog_rd_o && prog_addr_o == $past(prog_addr_o, 2) + 1'b1;
  endproperty
  a_select_linear: assert property (p_select_linear)
    else $error("select interrupted execution");
  property p_noop_linear;
    prog_rd_o ##1 nop |=> prog_rd_o && prog_addr_o == $past(prog_addr_o, 2) + 1'b1;
  endproperty
  a_noop_linear: assert property (p_noop_linear)
    else $error("no-op word broke the sequence");
  property p_noop_db_keep;
    prog_rd_o ##1 nop |=> $stable(db_num_o) && $stable(db_valid_o) && $stable(db_base_o);
  endproperty
  a_noop_db_keep: assert property (p_noop_db_keep)
    else $error("no-op word changed the data block");
  property p_call_u;
    prog_rd_o ##1 op == `BCS_OP_CALL_U |-> code_blk_o == {2'b01, prog_data_i[7:0]}
      ##1 prog_rd_o && (prog_addr_o == $past(code_base_i) || prog_addr_o == $past(prog_addr_o, 2) + 1'b1);
  endproperty
  a_call_u: assert property (p_call_u)
    else $error("unconditional call went astray");
  property p_call_c;
    prog_rd_o ##1 op == `BCS_OP_CALL_C |-> code_blk_o == {2'b10, prog_data_i[7:0]}
      ##1 prog_rd_o && (prog_addr_o == $past(code_base_i) || prog_addr_o == $past(prog_addr_o, 2) + 1'b1);
  endproperty
  a_call_c: assert property (p_call_c)
    else $error("conditional call went astray");
  property p_db_by_select;
    $rose(db_valid_o) || (db_valid_o && $changed(db_num_o)) |->
      $past(prog_rd_o, 2) && $past(op) == `BCS_OP_SEL_DB && db_num_o == $past(prog_data_i[7:0]);
  endproperty
  a_db_by_select: assert property (p_db_by_select)
    else $error("data block changed without a select");
  property p_rd_idle_zero;
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("read data outside the read answer cycle");
endmodule // bcs_seq_monitor
bind bcs_seq bcs_seq_monitor #(.AW(AW)) mon_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .prog_addr_o(prog_addr_o),
  .prog_rd_o(prog_rd_o), .prog_data_i(prog_data_i), .code_blk_o(code_blk_o),
  .code_base_i(code_base_i), .db_base_o(db_base_o), .db_valid_o(db_valid_o),
  .db_num_o(db_num_o));
`default_nettype wire

// ==== tb/bcs_prog_model.sv ====
/*
 stored program and code block start table facing the sequencer.
 assumes the bench fills both before it sets the run bit.
*/
`timescale 1ns/1ps
`default_nettype none
module bcs_prog_model #(
  parameter int AW = 16
) (
  input wire logic mclk_i,
  input wire logic [AW-1:0] prog_addr_i,
  input wire logic prog_rd_i,
  output logic [15:0] prog_data_o,
  input wire logic [9:0] code_blk_i,
  output logic [AW-1:0] code_base_o,
  output logic code_valid_o
);
  logic [15:0] mem [0:255];
  logic [AW-1:0] cbase [0:1023];
  logic cvalid [0:1023];
  initial begin
    for (int i = 0; i < 1024; i++) begin
      cvalid[i] = 1'b0;
      cbase[i] = '0;
      if (i < 256) mem[i] = 16'h0000;
    end
  end
  // word stands only in the execute cycle; scrambled after so stale data is never reused
  always @(posedge mclk_i) begin
    if (prog_rd_i) prog_data_o <= mem[prog_addr_i[7:0]];
    else prog_data_o <= ~prog_data_o;
  end
  assign code_base_o = cbase[code_blk_i];
  assign code_valid_o = cvalid[code_blk_i];
endmodule // bcs_prog_model
`default_nettype wire

// ==== tb/block_call_sequencer_tb_top.sv ====
/*
 self-checking bench of the block call sequencer.
 assumes the program model answers fetches and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcs_regs.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module block_call_sequencer_tb_top;
  typedef struct packed {
    logic [15:0] word, a1, a2, ea1;
    logic [2:0] fl;
  } bcs_row_t;
  // fl holds sign, zero and logic bit
  // no-op words overwrite places
  localparam bcs_row_t ROWS [0:9] = '{
    '{16'h0900, 16'h0003, 16'h0005, 16'h0008, 3'b000},
    '{16'h0A00, 16'h0008, 16'h0005, 16'hFFFD, 3'b100},
    '{16'h0900, 16'hFFFF, 16'h0001, 16'h0000, 3'b010},
    '{16'h0000, 16'h0007, 16'h0009, 16'h0007, 3'b000},
    '{16'hFFFF, 16'h0007, 16'h0009, 16'h0007, 3'b000},
    '{16'h0B82, 16'h0007, 16'h0009, 16'h0007, 3'b000},
    '{16'h0205, 16'h0001, 16'h0002, 16'h0001, 3'b001},
    '{16'h0106, 16'h0001, 16'h0002, 16'h0003, 3'b000},
    '{16'h0700, 16'h0001, 16'h0002, 16'h0001, 3'b001},
    '{16'h0307, 16'h0001, 16'h0002, 16'h0001, 3'b000}};
  logic mclk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, prog_data_i, rd_v;
  logic [15:0] prog_addr_o, code_base_i, db_base_o;
  logic [9:0] code_blk_o;
  logic prog_rd_o, code_valid_i, db_valid_o, running_o;
  logic [7:0] db_num_o;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  bcs_seq #(.AW(16)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o),
    .prog_data_i(prog_data_i), .code_blk_o(code_blk_o), .code_base_i(code_base_i),
    .code_valid_i(code_valid_i), .db_base_o(db_base_o), .db_valid_o(db_valid_o),
    .db_num_o(db_num_o), .running_o(running_o));
  bcs_prog_model #(.AW(16)) pm_u (.mclk_i(mclk_i), .prog_addr_i(prog_addr_o),
    .prog_rd_i(prog_rd_o), .prog_data_o(prog_data_i), .code_blk_i(code_blk_o),
    .code_base_o(code_base_i), .code_valid_o(code_valid_i));
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic rst(input int n);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask
  task automatic blk(input logic [9:0] n, input logic [7:0] b, input logic [15:0] w0, w1, w2, w3);
    pm_u.cvalid[n] = 1'b1;
    pm_u.cbase[n] = {8'h00, b};
    pm_u.mem[b] = w0;
    pm_u.mem[b + 8'h01] = w1;
    pm_u.mem[b + 8'h02] = w2;
    pm_u.mem[b + 8'h03] = w3;
  endtask
  task automatic run(input logic [15:0] a1, ctrl);
    bit seen = 0;
    wr(`BCS_REG_ACC1, a1);
    wr(`BCS_REG_START, 16'h0010);
    wr(`BCS_REG_CTRL, ctrl);
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk_i);
      #1;
      if (running_o === 1'b1) seen = 1;
      if (seen && running_o === 1'b0) break;
    end
    `CHK("stopped", 1'b0, running_o)
  endtask
  // main block: halt first so the block end after the tested word closes the scan
  task automatic gen(input logic [15:0] w, a1);
    blk(10'h3FF, 8'h10, 16'h0800, w, 16'h0500, 16'h0500);
    run(a1, 16'h0001);
  endtask
  task automatic free_is(input logic [15:0] e);
    rd(`BCS_REG_FREE);
    `CHK("free", e, rd_v)
  endtask
  initial begin
    rst(20);
    rd(`BCS_REG_CTRL);
    `CHK("ctrl", `BCS_RST_CTRL, rd_v)
    free_is(`BCS_RST_FREE);
    rd(`BCS_REG_START);
    `CHK("start", `BCS_RST_START, rd_v)
    rd(4'hF);
    `CHK("unmapped", 16'h0000, rd_v)
    wr(`BCS_REG_STATUS, 16'hFFFF);
    rd(`BCS_REG_STATUS);
    `CHK("status", 16'h0000, rd_v)
    // code blocks end with a block end
    blk(10'h106, 8'h40, 16'h0900, 16'h0600, 16'h0900, 16'h0500);
    blk(10'h205, 8'h48, 16'h0A00, 16'h0700, 16'h0900, 16'h0500);
    blk({2'b00, `BCS_ERR_OB}, 8'h50, 16'h0800, 16'h0500, 16'h0500, 16'h0500);
    foreach (ROWS[i]) begin
      rst(2);
      wr(`BCS_REG_ACC2, ROWS[i].a2);
      gen(ROWS[i].word, ROWS[i].a1);
      rd(`BCS_REG_ACC1);
      `CHK("acc1", ROWS[i].ea1, rd_v)
      rd(`BCS_REG_ACC2);
      `CHK("acc2", ROWS[i].a2, rd_v)
      rd(`BCS_REG_STATUS);
      `CHK("flags", ROWS[i].fl, rd_v[5:3])
      `CHK("halted", 3'b100, rd_v[2:0])
    end
    rst(2);
    wr(`BCS_REG_ACC2, 16'h0004);
    blk(10'h3FF, 8'h10, 16'h0800, 16'h0205, 16'h0205, 16'h0500);
    run(16'h0001, 16'h0001);
    rd(`BCS_REG_ACC1);
    `CHK("acc1_call", 16'h0003, rd_v)
    rd(`BCS_REG_STATUS);
    `CHK("logic_bit", 1'b1, rd_v[3])
    rst(2);
    blk(10'h3FF, 8'h10, 16'h0800, 16'h0407, 16'h0307, 16'h0500);
    run(16'h000F, 16'h0001);
    `CHK("db_valid", 1'b1, db_valid_o)
    `CHK("db_num", 8'h07, db_num_o)
    free_is(16'h0FF0);
    run(16'h0003, 16'h0001);
    free_is(16'h0FF0);
    gen(16'h0407, 16'h0000);
    free_is(16'h0FF0);
    gen(16'h0407, 16'h0001);
    free_is(16'h0FEE);
    gen(16'h0401, 16'h0001);
    free_is(16'h0FEE);
    gen(16'h04FF, 16'h0001);
    free_is(16'h0FEC);
    wr(`BCS_REG_CTRL, 16'h0004);
    free_is(16'h0FFC);
    rst(2);
    blk(10'h3FF, 8'h10, 16'h0409, 16'h0500, 16'h0500, 16'h0500);
    run(16'h1000, 16'h0001);
    rd(`BCS_REG_STATUS);
    `CHK("transfer_error_indication_stop", 2'b10, rd_v[1:0])
    rst(2);
    run(16'h1000, 16'h0003);
    rd(`BCS_REG_STATUS);
    `CHK("err_block", 3'b100, rd_v[2:0])
    results();
  end
endmodule // block_call_sequencer_tb_top
`default_nettype wire
